// ===== vdt_pkg.sv
// vdt_pkg: shared constants and types for the video dram transfer host
// assumes: 40 MHz system clock, apb software port, dram pins on the far side
`default_nettype none
package vdt_pkg;
  localparam int unsigned CLK_MHZ      = 40;
  // apb register byte offsets
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] STAT_OFS      = 8'h04;
  localparam logic [7:0] DATA_OFS      = 8'h08;
  localparam logic [7:0] SER_OFS       = 8'h0c;
  // control register fields
  localparam int unsigned CTRL_GO      = 0;
  localparam int unsigned CTRL_CMD_LO  = 1;
  localparam int unsigned CTRL_SPLIT   = 4;
  localparam int unsigned CTRL_SELF    = 5;
  localparam int unsigned CTRL_ADDR_LO = 8;
  localparam int unsigned CTRL_ADDR_W  = 9;
  // serial control fields
  localparam int unsigned SER_GO       = 0;
  localparam int unsigned SER_WR       = 1;
  localparam int unsigned SER_CNT_LO   = 8;
  localparam int unsigned SER_CNT_W    = 9;
  localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
  localparam logic [31:0] SER_RST      = 32'h0000_0000;
  // random port timing, ns, and derived cycle counts (rounded up)
  localparam int unsigned STROBE_NS    = 60;
  localparam int unsigned STROBE_CYC   = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned DT_HOLD_NS   = 55;
  localparam int unsigned DT_HOLD_CYC  = (DT_HOLD_NS * CLK_MHZ + 999) / 1000;
  // last data register location of each half
  localparam logic [8:0]  LAST_LO      = 9'h0ff;
  localparam logic [8:0]  LAST_HI      = 9'h1ff;

  typedef enum logic [2:0] {
    CMD_SET_COLOR = 3'h0,
    CMD_SET_MASK  = 3'h1,
    CMD_READ_XFER = 3'h2,
    CMD_WRITE_XFR = 3'h3
  } vdt_cmd_e;

  typedef struct packed {
    logic rasN;
    logic casN;
    logic xferOeN;      // transfer_output_enable, active low
    logic specialFunc;  // special_function_select
    logic [8:0] addr;
  } vdt_rnd_s;

  typedef struct packed {
    logic shiftClk;     // serial_shift_clock
    logic portEnN;      // serial_port_enable, active low
  } vdt_ser_s;
endpackage : vdt_pkg
`default_nettype wire

// ===== vdt_serial.sv
// vdt_serial: serial shift clock generator for the dram serial port
// assumes: divider clock, halfFlag and serial data inputs already synchronised
`default_nettype none
module vdt_serial
  import vdt_pkg::*;
#(
  parameter int unsigned DIV = 2
) (
  input  wire logic       clock,      // system clock
  input  wire logic       resetn,     // async reset, active low
  input  wire logic       start,      // pulse: begin a burst
  input  wire logic       writeMode,  // 1: serial write burst
  input  wire logic [8:0] count,      // edges in burst
  input  wire logic [8:0] startPtr,   // location latched by last transfer
  input  wire logic       blockEdge,  // split restricted period
  input  wire logic       dataIn,     // synchronised serial data in
  input  wire logic       wrData,     // bit to shift out in write mode
  output vdt_ser_s        serOut,     // serial clock and enable
  output logic            dataOut,    // serial data driven in write mode
  output logic            dataOutEnN, // low while driving serial data
  output logic            busy,       // burst running
  output logic [8:0]      ptr,        // tracked pointer
  output logic [31:0]     shiftReg    // captured read bits
);
  // the divider counter is only 8 bits wide
  if (DIV < 2 || DIV > 256) begin : g_divCheck
    $error("vdt_serial: DIV must be 2 to 256");
  end
  logic [7:0]  divCnt_q;
  logic [8:0]  seen_q;
  logic [8:0]  left_q;
  logic        sc_q;
  logic        run_q;
  logic        wr_q;
  logic [8:0]  ptr_q;
  logic [31:0] sh_q;
  wire         tick = (divCnt_q == 8'(DIV - 1));
  wire         rise = run_q && tick && !sc_q && !blockEdge;
  wire         fall = run_q && tick && sc_q;
  wire         isLast = (ptr_q == LAST_LO) || (ptr_q == LAST_HI);
  wire  [8:0]  nextPtr = isLast ? startPtr : ptr_q + 9'h001;
  // the pointer reloads when a transfer moves the start or after the last location, not per burst
  wire         newStart = (startPtr != seen_q);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      divCnt_q <= 8'h00;
      left_q   <= 9'h000;
      sc_q     <= 1'b0;
      run_q    <= 1'b0;
      wr_q     <= 1'b0;
      ptr_q    <= 9'h000;
      seen_q   <= 9'h000;
      sh_q     <= 32'h0000_0000;
    end else begin
      divCnt_q <= tick ? 8'h00 : divCnt_q + 8'h01;
      seen_q   <= startPtr;
      // advance on each edge; a new start from a transfer wins
      if (newStart) ptr_q <= startPtr;
      else if (rise) ptr_q <= nextPtr;
      if (start && !run_q) begin
        run_q  <= (count != 9'h000);
        left_q <= count;
        wr_q   <= writeMode;
      end else if (rise) begin
        sc_q  <= 1'b1;
        if (!wr_q) sh_q <= {sh_q[30:0], dataIn};
      end else if (fall) begin
        sc_q   <= 1'b0;
        left_q <= left_q - 9'h001;
        if (left_q == 9'h001) run_q <= 1'b0;
      end
    end
  end
  assign serOut.shiftClk = sc_q;
  assign serOut.portEnN  = !run_q;
  assign dataOut    = wrData;
  assign dataOutEnN = !(run_q && wr_q);
  assign busy       = run_q;
  assign ptr        = ptr_q;
  assign shiftReg   = sh_q;
endmodule : vdt_serial
`default_nettype wire

// ===== vdt_host.sv
// vdt_host: apb controlled host that drives a dual-port video dram
// assumes: dram pins external; halfFlag and serial data arrive asynchronously
`default_nettype none
module vdt_host
  import vdt_pkg::*;
(
  input  wire logic        clock,       // system clock 40 MHz
  input  wire logic        resetn,      // async reset, active low
  input  wire logic        psel,        // apb select
  input  wire logic        penable,     // apb enable
  input  wire logic        pwrite,      // apb direction
  input  wire logic [7:0]  paddr,       // apb byte address
  input  wire logic [31:0] pwdata,      // apb write data
  output logic [31:0]      prdata,      // apb read data
  output logic             pready,      // apb ready
  output logic             pslverr,     // apb error on unmapped address
  output vdt_rnd_s         rndPort,     // random port strobes and address
  output logic [7:0]       dataOut,     // random data bus out
  output logic [7:0]       dataOutEnN,  // low while driving data bus
  output vdt_ser_s         serPort,     // serial clock and enable
  output logic             serDataOut,  // serial data out
  output logic             serDataEnN,  // low while driving serial data
  input  wire logic        serDataIn,   // serial data pin in
  input  wire logic        halfFlagIn   // split_half_flag pin
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_RAS = 3'b001, ST_CAS = 3'b011,
    ST_XEND = 3'b010, ST_DONE = 3'b110
  } vdt_state_e;
  vdt_state_e  st_q, st_d;
  logic [31:0] ctrl_q, data_q, ser_q;
  logic [7:0]  cnt_q;
  logic [8:0]  start_q;
  logic        xferOe_q, rasN_q, casN_q, drive_q, sf_q;
  logic        hf1_q, hf2_q, sd1_q, sd2_q;
  logic [2:0]  pend_q;
  logic        serBusy;
  logic [8:0]  serPtr;
  logic [31:0] serShift;

  wire         acc     = psel && penable;
  wire         wrCtrl  = acc && pwrite && (paddr == CTRL_OFS);
  wire         wrData  = acc && pwrite && (paddr == DATA_OFS);
  wire         wrSer   = acc && pwrite && (paddr == SER_OFS);
  wire         mapped  = (paddr == CTRL_OFS) || (paddr == STAT_OFS) ||
                         (paddr == DATA_OFS) || (paddr == SER_OFS);
  wire  [2:0]  cmdRaw  = ctrl_q[CTRL_CMD_LO +: 3];
  wire         isSplit = ctrl_q[CTRL_SPLIT];
  wire         selfTim = ctrl_q[CTRL_SELF];
  wire  [8:0]  rowAddr = ctrl_q[CTRL_ADDR_LO +: CTRL_ADDR_W];
  wire         isXfer  = (cmdRaw == CMD_READ_XFER) || (cmdRaw == CMD_WRITE_XFR);
  wire         isReadX = (cmdRaw == CMD_READ_XFER);
  wire         cntDone = (cnt_q == 8'h00);
  // no split read during serial write
  // boundary covered by the same hold-off
  wire         splitRdHold = isReadX && isSplit && serBusy && ser_q[SER_WR];
  wire         goNow   = (st_q == ST_IDLE) && ctrl_q[CTRL_GO] && !splitRdHold;
  // freeze serial clock in split window
  wire         blockSc = isSplit && isXfer &&
                         ((st_q == ST_CAS) || (st_q == ST_XEND));
  // half flag toggles as the transfer ends; wait out the synchroniser
  wire         xferEnd = (st_q == ST_DONE) && cntDone && isXfer;

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE: if (goNow) st_d = ST_RAS;
      ST_RAS:  if (cntDone) st_d = ST_CAS;
      ST_CAS:  if (cntDone) st_d = isReadX ? ST_XEND : ST_DONE;
      ST_XEND: if (cntDone) st_d = ST_DONE;
      ST_DONE: if (cntDone) st_d = ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
  end

  wire [7:0] loadCnt = (st_q == ST_CAS && isReadX) ? 8'(DT_HOLD_CYC)
                                                   : 8'(STROBE_CYC);
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_q     <= ST_IDLE;
      cnt_q    <= 8'h00;
      ctrl_q   <= CTRL_RST;
      data_q   <= 32'h0000_0000;
      ser_q    <= SER_RST;
      start_q  <= 9'h000;
      rasN_q   <= 1'b1;
      casN_q   <= 1'b1;
      xferOe_q <= 1'b1;
      drive_q  <= 1'b0;
      sf_q     <= 1'b0;
      hf1_q    <= 1'b0;
      hf2_q    <= 1'b0;
      sd1_q    <= 1'b0;
      sd2_q    <= 1'b0;
      pend_q   <= 3'h0;
    end else begin
      pend_q <= {pend_q[1:0], xferEnd};
      hf1_q <= halfFlagIn;
      hf2_q <= hf1_q;
      sd1_q <= serDataIn;
      sd2_q <= sd1_q;
      st_q  <= st_d;
      cnt_q <= (st_d != st_q) ? loadCnt : (cntDone ? 8'h00 : cnt_q - 8'h01);
      if (wrCtrl) ctrl_q <= pwdata;
      else if (goNow) ctrl_q[CTRL_GO] <= 1'b0;
      if (wrData) data_q <= pwdata;
      if (wrSer) ser_q <= pwdata;
      else if (ser_q[SER_GO]) ser_q[SER_GO] <= 1'b0;
      if (goNow) begin
        sf_q     <= (cmdRaw == CMD_SET_COLOR);
        rasN_q   <= 1'b0;
        xferOe_q <= !isXfer;
        drive_q  <= !isXfer;
      end
      if (st_q == ST_RAS && cntDone) casN_q <= 1'b0;
      if (st_q == ST_XEND && cntDone && !selfTim) xferOe_q <= 1'b1;
      if (st_q == ST_DONE && cntDone) begin
        rasN_q   <= 1'b1;
        casN_q   <= 1'b1;
        xferOe_q <= 1'b1;
        drive_q  <= 1'b0;
      end
      // latch new start location once the flag has crossed over
      if (pend_q[2]) start_q <= {hf2_q, 8'h00};
    end
  end

  vdt_serial #(.DIV(2)) u_serial (
    .clock      (clock),
    .resetn     (resetn),
    .start      (ser_q[SER_GO]),
    .writeMode  (ser_q[SER_WR]),
    .count      (ser_q[SER_CNT_LO +: SER_CNT_W]),
    .startPtr   (start_q),
    .blockEdge  (blockSc),
    .dataIn     (sd2_q),
    .wrData     (data_q[0]),
    .serOut     (serPort),
    .dataOut    (serDataOut),
    .dataOutEnN (serDataEnN),
    .busy       (serBusy),
    .ptr        (serPtr),
    .shiftReg   (serShift)
  );

  assign rndPort.rasN        = rasN_q;
  assign rndPort.casN        = casN_q;
  assign rndPort.xferOeN     = xferOe_q;
  assign rndPort.specialFunc = sf_q;
  assign rndPort.addr        = rowAddr;
  assign dataOut    = data_q[7:0];
  assign dataOutEnN = {8{!drive_q}};
  assign pready     = 1'b1;
  assign pslverr    = acc && !mapped;
  always_comb begin
    prdata = 32'h0000_0000;
    if (paddr == CTRL_OFS) prdata = ctrl_q;
    else if (paddr == STAT_OFS)
      prdata = {11'h000, serPtr, 3'h0, splitRdHold, hf2_q, serBusy,
                st_q != ST_IDLE, 1'b0, st_q, 1'b0};
    else if (paddr == DATA_OFS) prdata = serShift;
    else if (paddr == SER_OFS) prdata = ser_q;
  end
endmodule : vdt_host
`default_nettype wire

// ===== vdt_host_monitor.sv
// vdt_host_monitor: port assertions for vdt_host
// assumes: bound onto vdt_host, one clock domain
`default_nettype none
module vdt_host_monitor
  import vdt_pkg::*;
(
  input wire logic       clock,   // system clock
  input wire logic       resetn,  // async reset, active low
  input wire logic       psel,    // apb select
  input wire logic       penable, // apb enable
  input wire logic [7:0] paddr,   // apb address
  input wire logic       pready,  // apb ready
  input wire logic       pslverr, // apb error
  input wire vdt_rnd_s   rndPort, // random port pins
  input wire vdt_ser_s   serPort  // serial port pins
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  wire acc = psel && penable;
  wire bad = paddr > SER_OFS;
  sequence s_rasHold; !rndPort.rasN [*4]; endsequence
  sequence s_casWait; rndPort.casN [*2]; endsequence
  sequence s_clkHigh; serPort.shiftClk [*2]; endsequence
  property p_ready; psel |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_slverr; acc && bad |-> pslverr; endproperty
  a_slverr: assert property (p_slverr) else $error("no error");
  property p_okay; acc && paddr[1:0] == 2'h0 && !bad |-> !pslverr; endproperty
  a_okay: assert property (p_okay) else $error("false error");
  property p_rasHold; $fell(rndPort.rasN) |-> s_rasHold; endproperty
  a_rasHold: assert property (p_rasHold) else $error("ras short");
  property p_casWait; $fell(rndPort.rasN) |-> s_casWait; endproperty
  a_casWait: assert property (p_casWait) else $error("cas early");
  property p_casInRas; !rndPort.casN |-> !rndPort.rasN; endproperty
  a_casInRas: assert property (p_casInRas) else $error("cas alone");
  property p_xferFirst; $rose(rndPort.rasN) |-> rndPort.xferOeN; endproperty
  a_xferFirst: assert property (p_xferFirst) else $error("oe late");
  property p_clkShape;
    $rose(serPort.shiftClk) |-> s_clkHigh ##1 !serPort.shiftClk;
  endproperty
  a_clkShape: assert property (p_clkShape) else $error("bad clock");
  property p_enClk; $rose(serPort.shiftClk) |-> !serPort.portEnN; endproperty
  a_enClk: assert property (p_enClk) else $error("edge no enable");
endmodule // vdt_host_monitor
`default_nettype wire

// ===== vdt_dram_model.sv
// vdt_dram_model: behavioural dual-port video dram
// assumes: pins straight from vdt_host, no electrical timing
`default_nettype none
module vdt_dram_model
  import vdt_pkg::*;
(
  input  wire vdt_rnd_s   rnd,      // random port strobes
  input  wire logic [7:0] dataIn,   // random data bus
  input  wire vdt_ser_s   ser,      // serial clock and enable
  output logic            serData,  // serial data to host
  output logic            halfFlag, // split_half_flag
  output logic [7:0]      colorQ,   // color register
  output logic [7:0]      maskQ,    // write mask register
  output logic [8:0]      ptrQ,     // serial pointer
  output int              badEdges  // edges in restricted period
);
  timeunit 1ns;
  timeprecision 1ps;
  logic xfer = 1'b0;
  initial {colorQ, maskQ, ptrQ, halfFlag, serData} = '0;
  initial badEdges = 0;
  // register select; cycle type read once the strobes have settled
  always @(negedge rnd.casN) begin
    xfer = !rnd.xferOeN;
    if (!xfer) begin
      if (rnd.specialFunc) colorQ = dataIn;
      else maskQ = dataIn;
    end
  end
  // transfer ends by ras rise at latest
  always @(posedge rnd.rasN) if (xfer) begin
    halfFlag = !halfFlag;
    ptrQ = {halfFlag, 8'h00};
    xfer = 1'b0;
  end
  // serial port advances on its own, wraps to start
  always @(posedge ser.shiftClk) if (!ser.portEnN) begin
    // last place hit during a transfer
    if (xfer && !rnd.casN && ptrQ[7:0] == 8'hff) badEdges++;
    ptrQ = ptrQ[7:0] == 8'hff ? {halfFlag, 8'h00} : ptrQ + 9'h001;
    serData = ptrQ[0];
  end
  // deselected line shows no stale value
  always @(posedge ser.portEnN) serData = !serData;
endmodule // vdt_dram_model
`default_nettype wire

// ===== vdt_host_tb.sv
// testbench: apb driven checks of vdt_host against a dram model
// assumes: package, host, model and monitor compiled first
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import vdt_pkg::*;
  logic clock = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, err, pready, pslverr, serDataOut, serDataEnN;
  logic serData, halfFlag;
  logic [7:0] paddr = 8'h00, dataOut, dataOutEnN, colorQ, maskQ;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [8:0] ptrQ;
  int badEdges, failures = 0, samples_checked = 0;
  vdt_rnd_s rndPort;
  vdt_ser_s serPort;
  // shared serial line: host drives only while writing
  wire serLine = serDataEnN ? serData : serDataOut;
  always #12.5 clock = !clock;
  vdt_host u_dut (.clock(clock), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rndPort(rndPort), .dataOut(dataOut), .dataOutEnN(dataOutEnN),
    .serPort(serPort), .serDataOut(serDataOut), .serDataEnN(serDataEnN),
    .serDataIn(serLine), .halfFlagIn(halfFlag));
  vdt_dram_model u_mem (.rnd(rndPort), .dataIn(dataOut), .ser(serPort),
    .serData(serData), .halfFlag(halfFlag), .colorQ(colorQ),
    .maskQ(maskQ), .ptrQ(ptrQ), .badEdges(badEdges));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // entered just after a rising edge; values taken as the edge sees them
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(posedge clock);
      if (pready === 1'b1) begin
        rd = prdata;
        err = pslverr;
        break;
      end
      if (i == 19) failures++;
      if (i == 19) test_done();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so the next setup never reassigns psel in this step
    @(posedge clock);
  endtask
  task automatic idle;
    for (int i = 0; i < 1000; i++) begin
      apb(1'b0, STAT_OFS, 32'h0);
      if (rd[6:5] === 2'b00) return;
    end
    failures++;
    test_done();
  endtask
  task automatic t_reset;
    apb(1'b0, CTRL_OFS, 32'h0);
    check(rd, CTRL_RST);
    apb(1'b0, SER_OFS, 32'h0);
    check(rd, SER_RST);
    check({rndPort.rasN, rndPort.casN, serPort.portEnN}, 3'h7);
    apb(1'b0, 8'h10, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0000_0000);
  endtask
  task automatic t_regset;
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, DATA_OFS, 32'h5a + s);
      apb(1'b1, CTRL_OFS, {28'h0, 3'(s), 1'b1});
      idle();
    end
    check(colorQ, 8'h5a);
    check(maskQ, 8'h5b);
  endtask
  task automatic t_serial;
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, CTRL_OFS, {26'h0, 1'(s), 1'b0, 3'h2, 1'b1});
      idle();
      check(halfFlag, 1'(s == 0));
    end
    apb(1'b1, SER_OFS, {15'h0, 9'd3, 8'h01});
    // a random cycle overlaps the burst
    apb(1'b1, DATA_OFS, 32'h33);
    apb(1'b1, CTRL_OFS, 32'h1);
    idle();
    check(colorQ, 8'h33);
    check(ptrQ, 9'h003);
    check(rd[20:12], 9'h003);
    apb(1'b1, SER_OFS, {15'h0, 9'd260, 8'h01});
    idle();
    check(ptrQ, 9'h007);
    check(rd[20:12], 9'h007);
    check(badEdges, 0);
    // each edge samples the bit of the previous one: 231..255 then 0..6
    apb(1'b0, DATA_OFS, 32'h0);
    check(rd, 32'haaaa_aaaa);
  endtask
  initial begin
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    t_reset();
    t_regset();
    t_serial();
    test_done();
  end
endmodule // testbench
bind vdt_host vdt_host_monitor u_mon (.clock(clock), .resetn(resetn),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
  .pslverr(pslverr), .rndPort(rndPort), .serPort(serPort));
`default_nettype wire
